// ===== gp_ext_src.sv
// Model of the external clock or gate source on the pin.
// Assumes the timer samples the pin on rising CLK edges.
`timescale 1ns/1ps
`default_nettype none
module gp_ext_src
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic run,
  input  wire logic lvl,
  output var  logic ext
);
  // Falling-edge changes keep the pin settled at the sampling edge
  always @(negedge clk or negedge rst_b)
    if (!rst_b)
      ext <= 1'b0;
    else
      ext <= run ? ~ext : lvl;
endmodule : gp_ext_src
`default_nettype wire

// ===== gp_timer.sv
// General-purpose 16-bit timer/counter (four count sources), its prescaler and pin edge detector.
// Assumes CLK is the instruction clock; all pins are synchronous to it.
//
// Summary of operation
// - Timer mode counts instruction cycles up to period, then zero, continues.
// - In idle, timer halts when stop-in-idle bit 13 is one.
// - Halted counting resumes from held value when idle ends.
// - Sync counter mode counts synchronised external rising edges, wraps after period.
// - Sync counter halts in idle only while stop-in-idle is one.
// - Async counter mode counts every external rising edge, wraps after period.
// - Async counter stops in idle when stop-in-idle is one.
// - Timer keeps running through idle unless stop-in-idle set; it stops in sleep.
// - Interrupt request on period match and on gate falling edge in gated mode.
// - Clock-source select one counts the external clock input.
// - Source select zero with gate enable one selects gated accumulation.
`timescale 1ns/1ps
`default_nettype none
`include "gp_timer_consts.svh"
module gp_timer
  import gp_timer_pkg::*;
#(
  parameter int WIDTH = `TMR_WIDTH
)
(
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RST_B,
  // Control word and period
  input  wire logic [`TMR_CTRL_WIDTH-1:0] TIMER_CONTROL_WORD,
  input  wire logic [WIDTH-1:0]           PERIOD_MATCH_VALUE,
  // Processor power state
  input  wire logic                       CPU_IDLE,
  input  wire logic                       CPU_SLEEP,
  // External clock / gate pin
  input  wire logic                       EXT_CLK_GATE,
  // Status
  output logic [WIDTH-1:0]                COUNT,
  output logic                            IRQ
);

////////////////////////////////////////////////////////////////////////////////
// Control decode

  logic       timer_on;
  logic       stop_in_idle;
  logic       clock_source_select;
  logic       gate_accumulate_enable;
  logic       async_select;
  prescale_t  pre_sel;
  count_src_t src;

  assign timer_on               = TIMER_CONTROL_WORD[`TMR_ON_BIT];
  assign stop_in_idle           = TIMER_CONTROL_WORD[`TMR_STOP_IDLE_BIT];
  assign clock_source_select    = TIMER_CONTROL_WORD[`TMR_SRC_SEL_BIT];
  assign gate_accumulate_enable = TIMER_CONTROL_WORD[`TMR_GATE_BIT];
  assign async_select           = TIMER_CONTROL_WORD[`TMR_ASYNC_BIT];
  assign pre_sel = prescale_t'(TIMER_CONTROL_WORD[`TMR_PRE_BIT_HI:`TMR_PRE_BIT_LO]);

  always_comb
  begin
    if (clock_source_select)
      src = async_select ? SRC_ASYNC : SRC_SYNC;
    else if (gate_accumulate_enable)
      src = SRC_GATED;
    else
      src = SRC_INSTR;
  end

////////////////////////////////////////////////////////////////////////////////
// Pin sampling and edge detection

  // The pin is taken as synchronous, so one stage of history is enough;
  // a truly asynchronous source would need a synchroniser in front.
  logic rise;
  logic fall;

  gp_edge_detect
  #(
    .IDLE_LEVEL (`TMR_PIN_RST)
  )
  pin_edge
  (
    .clk   (CLK),
    .rst_b (RST_B),
    .pin   (EXT_CLK_GATE),
    .rise  (rise),
    .fall  (fall)
  );

////////////////////////////////////////////////////////////////////////////////
// Source qualification

  // Idle halts only when stop-in-idle is set. Sleep stops the core clock, so
  // only the external modes advance there; this one-clock model approximates
  // that by ignoring sleep for the external sources.
  logic halt;
  logic instr_tick;
  logic gate_tick;
  logic ext_tick;
  logic src_tick;

  assign halt       = CPU_IDLE & stop_in_idle;
  assign instr_tick = ~CPU_SLEEP;
  assign gate_tick  = ~CPU_SLEEP & EXT_CLK_GATE;
  assign ext_tick   = rise;

  always_comb
  begin
    case (src)
      SRC_INSTR: src_tick = instr_tick;
      SRC_GATED: src_tick = gate_tick;
      SRC_SYNC:  src_tick = ext_tick;
      SRC_ASYNC: src_tick = ext_tick;
      default:   src_tick = 1'b0;
    endcase
  end

////////////////////////////////////////////////////////////////////////////////
// Prescaler

  // One ratio table serves every source, so the gated and external modes
  // divide exactly as the instruction-cycle mode does.
  localparam int PRE_WIDTH = `TMR_PRE_WIDTH;
  logic [PRE_WIDTH-1:0] pre_limit;
  logic                 pre_en;
  logic                 pre_clr;
  logic                 step;

  always_comb
  begin
    case (pre_sel)
      PRE_DIV1:   pre_limit = '0;
      PRE_DIV8:   pre_limit = PRE_WIDTH'(`TMR_DIV8_LIMIT);
      PRE_DIV64:  pre_limit = PRE_WIDTH'(`TMR_DIV64_LIMIT);
      PRE_DIV256: pre_limit = PRE_WIDTH'(`TMR_DIV256_LIMIT);
      default:    pre_limit = '0;
    endcase
  end

  assign pre_en  = timer_on & ~halt & src_tick;
  assign pre_clr = ~timer_on;

  gp_prescaler
  #(
    .PRE_WIDTH (PRE_WIDTH)
  )
  pre_div
  (
    .clk   (CLK),
    .rst_b (RST_B),
    .clr   (pre_clr),
    .tick  (pre_en),
    .limit (pre_limit),
    .step  (step)
  );

////////////////////////////////////////////////////////////////////////////////
// Counter

  // Compared against the live period input, so a new period applies at once.
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             match;

  assign match = (count_reg == PERIOD_MATCH_VALUE);

  always_comb
  begin
    count_next = count_reg;
    if (step)
    begin
      if (match)
        count_next = '0;
      else
        count_next = count_reg + WIDTH'(1);
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      count_reg <= WIDTH'(`TMR_COUNT_RST);
    else
      count_reg <= count_next;
  end

////////////////////////////////////////////////////////////////////////////////
// Interrupt request

  // A one-cycle pulse, not a sticky flag: whoever keeps the pending bit
  // latches it, so there is no set/clear race to settle here.
  logic irq_reg;
  logic irq_next;
  logic gate_fall;

  assign gate_fall = timer_on & (src == SRC_GATED) & fall;

  always_comb
  begin
    irq_next = 1'b0;
    if (step && match)
      irq_next = 1'b1;
    if (gate_fall)
      irq_next = 1'b1;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_next;
  end

  assign COUNT = count_reg;
  assign IRQ   = irq_reg;

endmodule : gp_timer

////////////////////////////////////////////////////////////////////////////////
// Edge detector for a pin that is already synchronous to the clock

module gp_edge_detect
#(
  parameter logic IDLE_LEVEL = `TMR_PIN_RST
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Pin and its edges
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic pin_reg;
  logic pin_next;

  always_comb
  begin
    pin_next = pin;
  end

  // Resetting to the idle level keeps a false edge from following reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pin_reg <= IDLE_LEVEL;
    else
      pin_reg <= pin_next;
  end

  assign rise = pin & ~pin_reg;
  assign fall = ~pin & pin_reg;

endmodule : gp_edge_detect

////////////////////////////////////////////////////////////////////////////////
// Prescaler: one step pulse per limit+1 qualified ticks

module gp_prescaler
#(
  parameter int PRE_WIDTH = `TMR_PRE_WIDTH
)
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Control
  input  wire logic                 clr,
  input  wire logic                 tick,
  input  wire logic [PRE_WIDTH-1:0] limit,
  // Divided enable
  output logic                      step
);

  logic [PRE_WIDTH-1:0] pre_reg;
  logic [PRE_WIDTH-1:0] pre_next;

  // A limit lowered below the running count ends the period at once
  // instead of letting the count run all the way round.
  always_comb
  begin
    pre_next = pre_reg;
    step     = 1'b0;
    if (clr)
      pre_next = '0;
    else if (tick)
    begin
      if (pre_reg >= limit)
      begin
        pre_next = '0;
        step     = 1'b1;
      end
      else
        pre_next = pre_reg + PRE_WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pre_reg <= '0;
    else
      pre_reg <= pre_next;
  end

endmodule : gp_prescaler
`default_nettype wire

// ===== gp_timer_consts.svh
// Constants for the general-purpose timer/counter: field positions, reset values, defaults.
// Assumes inclusion by gp_timer_pkg.sv and gp_timer.sv by bare name.
`ifndef GP_TIMER_CONSTS_SVH
`define GP_TIMER_CONSTS_SVH
`define TMR_WIDTH        16
`define TMR_CTRL_WIDTH   16
`define TMR_STOP_IDLE_BIT 13
`define TMR_PRE_BIT_HI   5
`define TMR_PRE_BIT_LO   4
`define TMR_GATE_BIT     6
`define TMR_SRC_SEL_BIT  1
`define TMR_ASYNC_BIT    2
`define TMR_ON_BIT       15
`define TMR_COUNT_RST    16'h0000
`define TMR_PERIOD_RST   16'hffff
`define TMR_PIN_RST      1'b0
`define TMR_PRE_WIDTH    8
`define TMR_DIV8_LIMIT   8'h07
`define TMR_DIV64_LIMIT  8'h3f
`define TMR_DIV256_LIMIT 8'hff
`endif

// ===== gp_timer_pkg.sv
// Types for the general-purpose timer/counter.
// Assumes nothing beyond the constants header.
`default_nettype none
`include "gp_timer_consts.svh"
package gp_timer_pkg;
  typedef enum logic [1:0]
  {
    SRC_INSTR = 2'b00,
    SRC_GATED = 2'b01,
    SRC_SYNC  = 2'b10,
    SRC_ASYNC = 2'b11
  } count_src_t;
  typedef enum logic [1:0]
  {
    PRE_DIV1   = 2'b00,
    PRE_DIV8   = 2'b01,
    PRE_DIV64  = 2'b10,
    PRE_DIV256 = 2'b11
  } prescale_t;
endpackage : gp_timer_pkg
`default_nettype wire

// ===== gp_timer_properties.sv
// Port checker for gp_timer.
// Assumes divide-by-one prescale for the step checks.
`timescale 1ns/1ps
`default_nettype none
module gp_timer_properties #(parameter int WIDTH = 16)
(
  input wire logic             CLK,
  input wire logic             RST_B,
  input wire logic [15:0]      TIMER_CONTROL_WORD,
  input wire logic [WIDTH-1:0] PERIOD_MATCH_VALUE,
  input wire logic             CPU_IDLE,
  input wire logic             CPU_SLEEP,
  input wire logic             EXT_CLK_GATE,
  input wire logic [WIDTH-1:0] COUNT,
  input wire logic             IRQ
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  wire logic [15:0] w   = TIMER_CONTROL_WORD;
  wire logic        go  = w[15] && !(CPU_IDLE && w[13]) && w[5:4] == 2'h0;
  wire logic        tm  = w[2:1] == 2'h0 && !CPU_SLEEP;
  wire logic        hit = COUNT == PERIOD_MATCH_VALUE;
  AST_INC: assert property (go && tm && !w[6] && !hit |=> COUNT == $past(COUNT) + 1'b1)
    else $error("no step");
  AST_WRAP: assert property (go && tm && !w[6] && hit |=> COUNT == '0 && IRQ)
    else $error("no wrap");
  AST_IDLE: assert property (w[15] && CPU_IDLE && w[13] |=> $stable(COUNT))
    else $error("idle moved");
  AST_EXT: assert property (go && w[1] && $past(RST_B) && $rose(EXT_CLK_GATE) && !hit
    |=> COUNT == $past(COUNT) + 1'b1) else $error("edge lost");
  AST_HOLD: assert property (w[1] && !$rose(EXT_CLK_GATE) |=> $stable(COUNT))
    else $error("moved without edge");
  AST_GLOW: assert property (w[6] && w[2:1] == 2'h0 && !EXT_CLK_GATE |=> $stable(COUNT))
    else $error("gate low moved");
  AST_GHIGH: assert property (go && tm && w[6] && EXT_CLK_GATE && !hit
    |=> COUNT == $past(COUNT) + 1'b1) else $error("gate high held");
  AST_GFALL: assert property (w[15] && w[6] && w[2:1] == 2'h0 && $past(RST_B)
    && $fell(EXT_CLK_GATE) |=> IRQ) else $error("no gate irq");
endmodule : gp_timer_properties
bind gp_timer gp_timer_properties #(.WIDTH(WIDTH)) chk_i (
  .CLK                (CLK),
  .RST_B              (RST_B),
  .TIMER_CONTROL_WORD (TIMER_CONTROL_WORD),
  .PERIOD_MATCH_VALUE (PERIOD_MATCH_VALUE),
  .CPU_IDLE           (CPU_IDLE),
  .CPU_SLEEP          (CPU_SLEEP),
  .EXT_CLK_GATE       (EXT_CLK_GATE),
  .COUNT              (COUNT),
  .IRQ                (IRQ)
);
`default_nettype wire

// ===== gp_timer_tb.sv
// Self-checking bench for gp_timer with an external pin source.
// Assumes one 25 MHz clock and no handshakes.
`timescale 1ns/1ps
`default_nettype none
module gp_timer_tb;
  logic        CLK   = 1'b0;
  logic        RST_B = 1'b0;
  logic [15:0] ctrl  = 16'h0000;
  logic [15:0] per   = 16'h0005;
  logic        idle  = 1'b0;
  logic        slp   = 1'b0;
  logic        run   = 1'b0;
  logic        lvl   = 1'b0;
  wire  logic  ext;
  logic [15:0] cnt;
  logic        irq;
  int          error_cnt = 0;
  int          n_checks  = 0;
  // Control word, {idle,sleep,run,level}, cycles, expected count
  logic [43:0] rows [14] = '{44'h8000_0_09_0003, 44'ha000_8_09_0000, 44'h8000_8_09_0003,
    44'h8002_2_09_0004, 44'h8006_2_09_0004, 44'ha006_a_09_0000, 44'ha002_a_09_0000,
    44'h8002_6_09_0004, 44'h8040_1_09_0002, 44'h8040_0_09_0000, 44'h8000_4_09_0000,
    44'h8010_0_11_0002, 44'h8002_a_09_0004, 44'h8020_0_80_0002};
  always #20 CLK = ~CLK;
  gp_ext_src src (.clk(CLK), .rst_b(RST_B), .run(run), .lvl(lvl), .ext(ext));
  gp_timer uut (.CLK(CLK), .RST_B(RST_B), .TIMER_CONTROL_WORD(ctrl), .PERIOD_MATCH_VALUE(per),
    .CPU_IDLE(idle), .CPU_SLEEP(slp), .EXT_CLK_GATE(ext), .COUNT(cnt), .IRQ(irq));
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task start(input logic [15:0] c, input logic [3:0] f);
    @(negedge CLK);
    RST_B <= 1'b0;
    ctrl  <= c;
    {idle, slp, run, lvl} <= f;
    @(negedge CLK);
    RST_B <= 1'b1;
  endtask : start
  task finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (3) @(negedge CLK);
    foreach (rows[i])
    begin
      start(rows[i][43:28], rows[i][27:24]);
      repeat (rows[i][23:16]) @(negedge CLK);
      chk("count", cnt, rows[i][15:0]);
    end
    per <= 16'h0002;
    start(16'h8000, 4'h0);
    repeat (3) @(negedge CLK);
    chk("wrap", cnt, 16'h0000);
    chk("irq", {15'h0000, irq}, 16'h0001);
    @(negedge CLK);
    chk("irq", {15'h0000, irq}, 16'h0000);
    per <= 16'h0010;
    start(16'h8040, 4'h1);
    repeat (3) @(negedge CLK);
    lvl <= 1'b0;
    repeat (2) @(negedge CLK);
    chk("gate", {15'h0000, irq}, 16'h0001);
    start(16'ha000, 4'h0);
    repeat (3) @(negedge CLK);
    idle <= 1'b1;
    repeat (4) @(negedge CLK);
    idle <= 1'b0;
    repeat (2) @(negedge CLK);
    chk("resume", cnt, 16'h0005);
    start(16'h8030, 4'h0);
    repeat (255) @(negedge CLK);
    chk("div256", cnt, 16'h0000);
    @(negedge CLK);
    chk("div256", cnt, 16'h0001);
    finish_test();
  end
endmodule : gp_timer_tb
`default_nettype wire
